// File: hdl/ddp_regs.svh
`ifndef DDP_REGS_SVH
`define DDP_REGS_SVH

// Register byte offsets on the APB bus.
`define DDP_OFF_CMD 12'h000
`define DDP_OFF_STAT 12'h004
`define DDP_OFF_CYL 12'h008
`define DDP_OFF_HEAD 12'h00c
`define DDP_OFF_ATTR 12'h010
`define DDP_OFF_SPT 12'h014
`define DDP_OFF_TEST 12'h018
`define DDP_OFF_CTRL 12'h01c

// Command codes carried in the command byte.
`define DDP_C_ATTN 8'h40
`define DDP_C_WRITE 8'h41
`define DDP_C_CYL_HI 8'h42
`define DDP_C_CYL_LO 8'h43
`define DDP_C_HEAD 8'h44
`define DDP_C_ATTR_NUM 8'h50
`define DDP_C_ATTR_VAL 8'h51
`define DDP_C_SPIN 8'h55
`define DDP_C_SPT_HI 8'h59
`define DDP_C_SPT_MD 8'h5a
`define DDP_C_SPT_LO 8'h5b
`define DDP_C_TEST 8'h6f

// Parameter bit that selects enable, write enable or spin up.
`define DDP_P_SEL 7

// Status register bit positions.
`define DDP_S_ATT_EN 0
`define DDP_S_WR_EN 1
`define DDP_S_ATT 2
`define DDP_S_ILL_PAR 3
`define DDP_S_BUSY 4
`define DDP_S_SPIN 5
`define DDP_S_SENSE1_B0 6
`define DDP_S_MOV 7

// Control register bit positions.
`define DDP_K_CLR_ATT 0
`define DDP_K_PART 1

// Attribute table.
`define DDP_ATTR_DEPTH 32
`define DDP_ATTR_SPT_HI 8'h16
`define DDP_ATTR_SPT_MD 8'h17
`define DDP_ATTR_SPT_LO 8'h18

// Reset values, and the highest head number accepted.
`define DDP_ATT_EN_RST 1'b1
`define DDP_WR_EN_RST 1'b0
`define DDP_CYL_RST 16'h0000
`define DDP_HEAD_RST 8'h00
`define DDP_SPIN_RST 1'b0
`define DDP_HEAD_MAX 8'h07

// Timing, with counts derived from the 100 MHz clock.
`define DDP_CLK_MHZ 100
`define DDP_SPIN_TIME_MS 1
`define DDP_LAND_TIME_US 20
`define DDP_PART_TIME_US 1
`define DDP_SPIN_CYC (`DDP_SPIN_TIME_MS * 1000 * `DDP_CLK_MHZ)
`define DDP_LAND_CYC (`DDP_LAND_TIME_US * `DDP_CLK_MHZ)
`define DDP_PART_CYC (`DDP_PART_TIME_US * `DDP_CLK_MHZ)

`endif

// File: hdl/ddp_pkg.sv
`default_nettype none
package ddp_pkg;
  `include "ddp_regs.svh"

  typedef enum logic [2:0] {
    EX_IDLE,
    EX_UP,
    EX_LAND,
    EX_STOP,
    EX_PART
  } ddp_ex_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ddp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ddp_apb_rsp_t;

  typedef struct packed {
    logic attn;
    logic radial_att;
    logic busy;
    logic write_circuit;
    logic motor;
    logic mov_heads;
    logic [7:0] head_sel;
  } ddp_pins_t;

  typedef struct packed {
    logic att_en;
    logic wr_en;
    logic att_cond;
    logic ill_par;
    logic spinning;
    logic sense1_b0;
    logic [15:0] cyl;
    logic [7:0] attr_idx;
    logic [23:0] spt;
    logic [7:0] test;
    logic [`DDP_ATTR_DEPTH-1:0][7:0] attr;
    ddp_ex_t exec;
    logic [23:0] cnt;
    ddp_apb_rsp_t rsp;
    ddp_pins_t pins;
  } ddp_st_t;
endpackage : ddp_pkg
`default_nettype wire

// File: hdl/ddp_cmd.sv
// What this block does
// - Attention command bit7: zero enables, one disables.
// - Enabled attention drives the wired-OR line.
// - Radial status ignores attention enable.
// - Attention path enabled after reset.
// - Write command sets write enable; gate needs it.
// - Gate with write disabled records nothing.
// - Write enable cleared after reset.
// - Cylinder commands load high/low target byte.
// - Cylinder load: no motion, no error.
// - Target cylinder zero after reset.
// - Head select loads head, enables moving heads.
// - Out-of-range head sets attention, illegal parameter.
// - Moving head zero selected after reset.
// - Attribute number command loads index, anytime.
// - Attribute value goes to indexed attribute.
// - Spin command when idle; attention at end or immediately.
// - Busy held while spin cycle runs.
// - Spin down parks heads; failure sets sense bit.
// - Three commands stage 24-bit sector pulse count.
// - Partition end copies staged bytes to attributes.
// - Test byte stored for later echo.
`include "ddp_regs.svh"
`default_nettype none
module ddp_cmd #(
  parameter int unsigned SPIN_CYC = `DDP_SPIN_CYC
) (
  input wire logic pclk, // APB clock, 100 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire ddp_pkg::ddp_apb_req_t apb_req, // APB request from master.
  output var ddp_pkg::ddp_apb_rsp_t apb_rsp, // APB response, registered.
  input wire logic write_gate_i, // Write gate from the host.
  input wire logic land_fault_i, // High when the landing zone cannot be reached.
  output var ddp_pkg::ddp_pins_t pins_o // Drive pins, registered.
);
  import ddp_pkg::*;

  localparam logic [23:0] SPIN_LAST = 24'(SPIN_CYC - 1);
  localparam logic [23:0] LAND_LAST = 24'(`DDP_LAND_CYC - 1);
  localparam logic [23:0] PART_LAST = 24'(`DDP_PART_CYC - 1);

  ddp_st_t st_ff;
  ddp_st_t nxt_st;
  logic acc;
  logic wr_acc;
  logic cmd_fire;
  logic [7:0] code;
  logic [7:0] prm;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `DDP_OFF_CMD) || (a == `DDP_OFF_STAT) || (a == `DDP_OFF_CYL) ||
             (a == `DDP_OFF_HEAD) || (a == `DDP_OFF_ATTR) || (a == `DDP_OFF_SPT) ||
             (a == `DDP_OFF_TEST) || (a == `DDP_OFF_CTRL);
  endfunction : mapped

  function automatic logic [7:0] attr_rd(input ddp_st_t s);
    attr_rd = (s.attr_idx < 8'(`DDP_ATTR_DEPTH)) ? s.attr[s.attr_idx[4:0]] : 8'h00;
  endfunction : attr_rd

  function automatic logic [31:0] rd_mux(input logic [11:0] a, input ddp_st_t s);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `DDP_OFF_STAT: begin
        d[`DDP_S_ATT_EN] = s.att_en;
        d[`DDP_S_WR_EN] = s.wr_en;
        d[`DDP_S_ATT] = s.att_cond;
        d[`DDP_S_ILL_PAR] = s.ill_par;
        d[`DDP_S_BUSY] = (s.exec != EX_IDLE);
        d[`DDP_S_SPIN] = s.spinning;
        d[`DDP_S_SENSE1_B0] = s.sense1_b0;
        d[`DDP_S_MOV] = s.pins.mov_heads;
      end
      `DDP_OFF_CYL: d[15:0] = s.cyl;
      `DDP_OFF_HEAD: d[7:0] = s.pins.head_sel;
      `DDP_OFF_ATTR: d[15:0] = {s.attr_idx, attr_rd(s)};
      `DDP_OFF_SPT: d[23:0] = s.spt;
      `DDP_OFF_TEST: d[7:0] = s.test;
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : rd_mux

  // A transfer is answered in its first access cycle; writes land at that edge.
  assign acc = apb_req.psel && apb_req.penable && st_ff.rsp.pready;
  assign wr_acc = acc && apb_req.pwrite && !st_ff.rsp.pslverr;
  assign cmd_fire = wr_acc && (apb_req.paddr == `DDP_OFF_CMD);
  assign code = apb_req.pwdata[15:8];
  assign prm = apb_req.pwdata[7:0];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp.pready = 1'b0;
    nxt_st.rsp.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      nxt_st.rsp.pready = 1'b1;
      nxt_st.rsp.pslverr = !mapped(apb_req.paddr);
      nxt_st.rsp.prdata = rd_mux(apb_req.paddr, st_ff);
    end

    // Software clears first so that a same-cycle event still sets.
    if (wr_acc && (apb_req.paddr == `DDP_OFF_CTRL)) begin
      if (apb_req.pwdata[`DDP_K_CLR_ATT]) begin
        nxt_st.att_cond = 1'b0;
        nxt_st.ill_par = 1'b0;
        nxt_st.sense1_b0 = 1'b0;
      end
      if (apb_req.pwdata[`DDP_K_PART] && (st_ff.exec == EX_IDLE)) begin
        nxt_st.exec = EX_PART;
        nxt_st.cnt = PART_LAST;
      end
    end

    if (cmd_fire) begin
      case (code)
        `DDP_C_ATTN: nxt_st.att_en = !prm[`DDP_P_SEL];
        `DDP_C_WRITE: nxt_st.wr_en = prm[`DDP_P_SEL];
        `DDP_C_CYL_HI: nxt_st.cyl[15:8] = prm;
        `DDP_C_CYL_LO: nxt_st.cyl[7:0] = prm;
        `DDP_C_HEAD: begin
          nxt_st.pins.mov_heads = 1'b1;
          if (prm > `DDP_HEAD_MAX) begin
            nxt_st.att_cond = 1'b1;
            nxt_st.ill_par = 1'b1;
          end else begin
            nxt_st.pins.head_sel = prm;
          end
        end
        `DDP_C_ATTR_NUM: nxt_st.attr_idx = prm;
        `DDP_C_ATTR_VAL: begin
          if (st_ff.attr_idx < 8'(`DDP_ATTR_DEPTH)) begin
            nxt_st.attr[st_ff.attr_idx[4:0]] = prm;
          end
        end
        `DDP_C_SPIN: begin
          if (st_ff.exec == EX_IDLE) begin
            if (prm[`DDP_P_SEL] == st_ff.spinning) begin
              nxt_st.att_cond = 1'b1;
            end else if (prm[`DDP_P_SEL]) begin
              nxt_st.exec = EX_UP;
              nxt_st.cnt = SPIN_LAST;
            end else begin
              nxt_st.exec = EX_LAND;
              nxt_st.cnt = LAND_LAST;
            end
          end
        end
        `DDP_C_SPT_HI: nxt_st.spt[23:16] = prm;
        `DDP_C_SPT_MD: nxt_st.spt[15:8] = prm;
        `DDP_C_SPT_LO: nxt_st.spt[7:0] = prm;
        `DDP_C_TEST: nxt_st.test = prm;
        default: nxt_st.test = st_ff.test;
      endcase
    end

    if (st_ff.exec != EX_IDLE) begin
      nxt_st.cnt = st_ff.cnt - 24'h00_0001;
      if (st_ff.cnt == 24'h00_0000) begin
        nxt_st.exec = EX_IDLE;
        // The landing step hands over to the stop step without touching attention, so a clear still lands.
        case (st_ff.exec)
          EX_UP: begin
            nxt_st.spinning = 1'b1;
            nxt_st.att_cond = 1'b1;
          end
          EX_LAND: begin
            if (land_fault_i) begin
              nxt_st.sense1_b0 = 1'b1;
              nxt_st.att_cond = 1'b1;
            end else begin
              nxt_st.exec = EX_STOP;
              nxt_st.cnt = SPIN_LAST;
            end
          end
          EX_STOP: begin
            nxt_st.spinning = 1'b0;
            nxt_st.att_cond = 1'b1;
          end
          EX_PART: begin
            nxt_st.attr[`DDP_ATTR_SPT_HI] = st_ff.spt[23:16];
            nxt_st.attr[`DDP_ATTR_SPT_MD] = st_ff.spt[15:8];
            nxt_st.attr[`DDP_ATTR_SPT_LO] = st_ff.spt[7:0];
            nxt_st.att_cond = 1'b1;
          end
          default: nxt_st.exec = EX_IDLE;
        endcase
      end
    end

    nxt_st.pins.attn = nxt_st.att_en && nxt_st.att_cond;
    nxt_st.pins.radial_att = nxt_st.att_cond;
    nxt_st.pins.busy = (nxt_st.exec != EX_IDLE);
    nxt_st.pins.write_circuit = nxt_st.wr_en && write_gate_i;
    nxt_st.pins.motor = (nxt_st.exec == EX_UP) || (nxt_st.spinning && (nxt_st.exec != EX_STOP));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.att_en <= `DDP_ATT_EN_RST;
      st_ff.wr_en <= `DDP_WR_EN_RST;
      st_ff.cyl <= `DDP_CYL_RST;
      st_ff.pins.head_sel <= `DDP_HEAD_RST;
      st_ff.pins.mov_heads <= 1'b1;
      st_ff.spinning <= `DDP_SPIN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign apb_rsp = st_ff.rsp;
  assign pins_o = st_ff.pins;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_ATT_SEL: assert property (cmd_fire && code == `DDP_C_ATTN |=> st_ff.att_en == !$past(prm[7]))
    else $error("attention enable does not follow parameter bit 7");
  AST_ATT_LINE: assert property (st_ff.att_cond && !st_ff.att_en |-> !pins_o.attn)
    else $error("attention driven while disabled");
  AST_RADIAL: assert property (st_ff.att_cond |-> pins_o.radial_att)
    else $error("radial status lost attention");
  AST_WREN: assert property (cmd_fire && code == `DDP_C_WRITE |=> st_ff.wr_en == $past(prm[7]))
    else $error("write enable not loaded");
  AST_NOREC: assert property (!st_ff.wr_en && !$past(st_ff.wr_en) |-> !pins_o.write_circuit)
    else $error("writing while write disabled");
  AST_CYL: assert property (cmd_fire && code == `DDP_C_CYL_LO |=> st_ff.cyl[7:0] == $past(prm) ##0 !$rose(pins_o.busy))
    else $error("cylinder low byte wrong");
  AST_HEAD_BAD: assert property (cmd_fire && code == `DDP_C_HEAD && prm > `DDP_HEAD_MAX |=> st_ff.ill_par && st_ff.att_cond)
    else $error("bad head not flagged");
  AST_HEAD: assert property (cmd_fire && code == `DDP_C_HEAD && prm <= `DDP_HEAD_MAX |=> ##1 pins_o.head_sel == $past(prm, 2))
    else $error("head not selected");
  AST_SPIN_SAME: assert property (cmd_fire && code == `DDP_C_SPIN && st_ff.exec == EX_IDLE && prm[7] == st_ff.spinning |=> st_ff.att_cond)
    else $error("no immediate attention on spin");
  AST_BUSY: assert property ((st_ff.exec != EX_IDLE) |-> pins_o.busy)
    else $error("busy missing during execution");
  AST_SPT: assert property (st_ff.exec == EX_PART && st_ff.cnt == 24'h0 |=> st_ff.attr[24] == $past(st_ff.spt[7:0]))
    else $error("sector pulse low byte not copied");
  AST_TEST: assert property (cmd_fire && code == `DDP_C_TEST |=> st_ff.test == $past(prm))
    else $error("test byte not stored");

  // Every setting but the three attribute slots filled at partition end moves only on its own command, so a stray write cannot disturb it.
  property p_att_on;
    st_ff.att_cond && st_ff.att_en |-> pins_o.attn;
  endproperty : p_att_on
  AST_ATT_ON: assert property (p_att_on)
    else $error("attention kept off the line while enabled");
  property p_att_keep;
    !(cmd_fire && code == `DDP_C_ATTN) |=> $stable(st_ff.att_en);
  endproperty : p_att_keep
  AST_ATT_KEEP: assert property (p_att_keep)
    else $error("attention enable moved without a command");
  property p_radial_eq;
    pins_o.radial_att == st_ff.att_cond;
  endproperty : p_radial_eq
  AST_RADIAL_EQ: assert property (p_radial_eq)
    else $error("radial status differs from attention condition");
  property p_wr_gate;
    st_ff.wr_en && $past(write_gate_i) |-> pins_o.write_circuit;
  endproperty : p_wr_gate
  AST_WR_GATE: assert property (p_wr_gate)
    else $error("write gate ignored while write enabled");
  property p_wr_off;
    !st_ff.wr_en |-> !pins_o.write_circuit;
  endproperty : p_wr_off
  AST_WR_OFF: assert property (p_wr_off)
    else $error("write circuit active while write disabled");
  property p_wr_keep;
    !(cmd_fire && code == `DDP_C_WRITE) |=> $stable(st_ff.wr_en);
  endproperty : p_wr_keep
  AST_WR_KEEP: assert property (p_wr_keep)
    else $error("write enable moved without a command");
  property p_cyl_hi;
    cmd_fire && code == `DDP_C_CYL_HI |=> st_ff.cyl[15:8] == $past(prm);
  endproperty : p_cyl_hi
  AST_CYL_HI: assert property (p_cyl_hi)
    else $error("cylinder high byte wrong");
  property p_cyl_quiet;
    cmd_fire && (code == `DDP_C_CYL_HI || code == `DDP_C_CYL_LO) |=>
      $stable(st_ff.ill_par) && $stable(pins_o.head_sel);
  endproperty : p_cyl_quiet
  AST_CYL_QUIET: assert property (p_cyl_quiet)
    else $error("cylinder load raised an error or moved heads");
  property p_cyl_keep;
    !(cmd_fire && (code == `DDP_C_CYL_HI || code == `DDP_C_CYL_LO)) |=> $stable(st_ff.cyl);
  endproperty : p_cyl_keep
  AST_CYL_KEEP: assert property (p_cyl_keep)
    else $error("target cylinder moved without a command");
  property p_mov;
    cmd_fire && code == `DDP_C_HEAD |=> pins_o.mov_heads;
  endproperty : p_mov
  AST_MOV: assert property (p_mov)
    else $error("moving heads not enabled");
  property p_head_keep;
    cmd_fire && code == `DDP_C_HEAD && prm > `DDP_HEAD_MAX |=> $stable(pins_o.head_sel);
  endproperty : p_head_keep
  AST_HEAD_KEEP: assert property (p_head_keep)
    else $error("bad head number changed the selection");
  property p_ill_rise;
    $rose(st_ff.ill_par) |-> $past(cmd_fire && code == `DDP_C_HEAD && prm > `DDP_HEAD_MAX);
  endproperty : p_ill_rise
  AST_ILL_RISE: assert property (p_ill_rise)
    else $error("illegal parameter set without a bad head");
  property p_attr_idx;
    cmd_fire && code == `DDP_C_ATTR_NUM |=> st_ff.attr_idx == $past(prm);
  endproperty : p_attr_idx
  AST_ATTR_IDX: assert property (p_attr_idx)
    else $error("attribute index not loaded");
  property p_attr_val;
    cmd_fire && code == `DDP_C_ATTR_VAL && st_ff.attr_idx < 8'(`DDP_ATTR_DEPTH) && st_ff.exec == EX_IDLE |=>
      attr_rd(st_ff) == $past(prm);
  endproperty : p_attr_val
  AST_ATTR_VAL: assert property (p_attr_val)
    else $error("attribute value not written");
  property p_spin_go;
    cmd_fire && code == `DDP_C_SPIN && st_ff.exec == EX_IDLE && prm[`DDP_P_SEL] != st_ff.spinning |=>
      pins_o.busy && ((st_ff.exec == EX_UP) == $past(prm[`DDP_P_SEL]));
  endproperty : p_spin_go
  AST_SPIN_GO: assert property (p_spin_go)
    else $error("spin cycle started in the wrong direction");
  property p_spin_done;
    st_ff.exec == EX_UP && st_ff.cnt == 24'h0 |=> st_ff.spinning && st_ff.att_cond && !pins_o.busy;
  endproperty : p_spin_done
  AST_SPIN_DONE: assert property (p_spin_done)
    else $error("spin up end not reported");
  property p_busy_exec;
    pins_o.busy |-> st_ff.exec != EX_IDLE;
  endproperty : p_busy_exec
  AST_BUSY_EXEC: assert property (p_busy_exec)
    else $error("busy shown with nothing executing");
  property p_part_busy;
    wr_acc && apb_req.paddr == `DDP_OFF_CTRL && apb_req.pwdata[`DDP_K_PART] && st_ff.exec == EX_IDLE |=>
      pins_o.busy;
  endproperty : p_part_busy
  AST_PART_BUSY: assert property (p_part_busy)
    else $error("partition track not busy");
  property p_land_fail;
    st_ff.exec == EX_LAND && st_ff.cnt == 24'h0 && land_fault_i |=>
      st_ff.att_cond && st_ff.sense1_b0 && !pins_o.busy;
  endproperty : p_land_fail
  AST_LAND_FAIL: assert property (p_land_fail)
    else $error("landing failure not reported");
  property p_land_ok;
    st_ff.exec == EX_LAND && st_ff.cnt == 24'h0 && !land_fault_i |=> st_ff.exec == EX_STOP && !pins_o.motor;
  endproperty : p_land_ok
  AST_LAND_OK: assert property (p_land_ok)
    else $error("spindle not stopped after landing");
  property p_stop;
    st_ff.exec == EX_STOP && st_ff.cnt == 24'h0 |=> !st_ff.spinning && st_ff.att_cond;
  endproperty : p_stop
  AST_STOP: assert property (p_stop)
    else $error("spin down end not reported");
  property p_test_keep;
    !(cmd_fire && code == `DDP_C_TEST) |=> $stable(st_ff.test);
  endproperty : p_test_keep
  AST_TEST_KEEP: assert property (p_test_keep)
    else $error("test byte moved without a command");

  // The three staged bytes share one shape: a load command each and an attribute slot each.
  for (genvar g = 0; g < 3; g++) begin : g_spt
    localparam logic [7:0] SPT_CODE = 8'(`DDP_C_SPT_HI + g);
    localparam int SPT_LSB = 8 * (2 - g);
    localparam int SPT_ATTR = `DDP_ATTR_SPT_HI + g;
    property p_spt_stage;
      cmd_fire && code == SPT_CODE |=> st_ff.spt[SPT_LSB +: 8] == $past(prm);
    endproperty : p_spt_stage
    AST_SPT_STAGE: assert property (p_spt_stage)
      else $error("sector pulse byte not staged");
    property p_spt_copy;
      st_ff.exec == EX_PART && st_ff.cnt == 24'h0 |=> st_ff.attr[SPT_ATTR] == $past(st_ff.spt[SPT_LSB +: 8]);
    endproperty : p_spt_copy
    AST_SPT_COPY: assert property (p_spt_copy)
      else $error("sector pulse byte not copied");
  end : g_spt

  COV_SPIN_UP: cover property (st_ff.exec == EX_UP ##1 st_ff.exec == EX_UP);
  COV_LAND_FAIL: cover property (st_ff.exec == EX_LAND && st_ff.cnt == 24'h0 && land_fault_i);
  COV_PART: cover property (st_ff.exec == EX_PART ##1 st_ff.exec == EX_IDLE);
  COV_ATT_OFF: cover property (st_ff.att_cond && !st_ff.att_en);
  COV_HEAD_BAD: cover property (cmd_fire && code == `DDP_C_HEAD && prm > `DDP_HEAD_MAX);
endmodule : ddp_cmd
`default_nettype wire

// File: verif/ddp_host_model.sv
`default_nettype none
module ddp_host_model (
  input wire logic pclk, // Device clock.
  input wire logic presetn, // Reset, active low.
  input wire logic gate_req, // Bench asks for a write operation.
  input wire logic fault_req, // Bench asks the park move to fail.
  input wire ddp_pkg::ddp_pins_t pins, // Device drive pins.
  output var logic write_gate, // Write gate to the device.
  output var logic land_fault, // Park failure seen by the device.
  output var logic attn_line // Wired-OR attention line.
);
  import ddp_pkg::*;
  // The line is pulled down and the other devices on it stay quiet.
  assign attn_line = pins.attn;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_gate <= 1'b0;
      land_fault <= 1'b0;
    end else begin
      write_gate <= gate_req;
      land_fault <= fault_req;
    end
  end
endmodule : ddp_host_model
`default_nettype wire

// File: verif/test_disk_drive_param_out_commands.sv
`include "ddp_regs.svh"
`default_nettype none
module test_disk_drive_param_out_commands;
  timeunit 1ns;
  timeprecision 1ns;
  import ddp_pkg::*;
  logic pclk, presetn, gate_req, fault_req, write_gate, land_fault, attn_line, slv;
  ddp_apb_req_t req;
  ddp_apb_rsp_t rsp;
  ddp_pins_t pins;
  int n_errors, cmp_count, cycles;
  logic [31:0] rv;
  logic [7:0] spt [3] = '{8'h12, 8'h34, 8'h56};

  ddp_cmd #(.SPIN_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .write_gate_i(write_gate), .land_fault_i(land_fault), .pins_o(pins));
  ddp_host_model host (.pclk(pclk), .presetn(presetn), .gate_req(gate_req), .fault_req(fault_req),
    .pins(pins), .write_gate(write_gate), .land_fault(land_fault), .attn_line(attn_line));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n == 20) begin
      n_errors++;
    end
    rv = rsp.prdata;
    slv = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer

  task automatic cmd(input logic [7:0] c, input logic [7:0] p);
    xfer(1'b1, `DDP_OFF_CMD, {16'h0000, c, p});
  endtask : cmd

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rv & 32'h00ff_ffff, e);
  endtask : rchk

  task automatic clr();
    xfer(1'b1, `DDP_OFF_CTRL, 32'h1);
  endtask : clr

  task automatic waitidle();
    int n;
    n = 0;
    do begin
      xfer(1'b0, `DDP_OFF_STAT, 32'h0);
      n++;
    end while (rv[`DDP_S_BUSY] !== 1'b0 && n < 1500);
  endtask : waitidle

  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask : settle

  initial begin
    req = '0;
    gate_req = 1'b0;
    fault_req = 1'b0;
    presetn = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`DDP_OFF_STAT, 32'h81);
    rchk(`DDP_OFF_CYL, 32'h0);
    rchk(`DDP_OFF_HEAD, 32'h0);
    xfer(1'b0, 12'h020, 32'h0);
    chk({31'h0, slv}, 32'h1);
    cmd(`DDP_C_SPIN, 8'h00);
    rchk(`DDP_OFF_STAT, 32'h85);
    chk({31'h0, attn_line}, 32'h1);
    cmd(`DDP_C_ATTN, 8'h80);
    rchk(`DDP_OFF_STAT, 32'h84);
    chk({30'h0, attn_line, pins.radial_att}, 32'h1);
    cmd(`DDP_C_ATTN, 8'h00);
    rchk(`DDP_OFF_STAT, 32'h85);
    chk({31'h0, attn_line}, 32'h1);
    clr();
    gate_req <= 1'b1;
    settle();
    chk({31'h0, pins.write_circuit}, 32'h0);
    gate_req <= 1'b0;
    settle();
    cmd(`DDP_C_WRITE, 8'h80);
    rchk(`DDP_OFF_STAT, 32'h83);
    gate_req <= 1'b1;
    settle();
    chk({31'h0, pins.write_circuit}, 32'h1);
    gate_req <= 1'b0;
    settle();
    cmd(`DDP_C_WRITE, 8'h00);
    rchk(`DDP_OFF_STAT, 32'h81);
    cmd(`DDP_C_CYL_HI, 8'hff);
    cmd(`DDP_C_CYL_LO, 8'hfe);
    rchk(`DDP_OFF_CYL, 32'hfffe);
    rchk(`DDP_OFF_STAT, 32'h81);
    cmd(`DDP_C_HEAD, 8'h07);
    settle();
    chk({24'h0, pins.head_sel}, 32'h7);
    chk({31'h0, pins.mov_heads}, 32'h1);
    cmd(`DDP_C_HEAD, 8'h08);
    rchk(`DDP_OFF_STAT, 32'h8d);
    rchk(`DDP_OFF_HEAD, 32'h7);
    clr();
    cmd(`DDP_C_ATTR_NUM, 8'h1f);
    cmd(`DDP_C_ATTR_VAL, 8'ha5);
    rchk(`DDP_OFF_ATTR, 32'h1fa5);
    cmd(`DDP_C_SPIN, 8'h80);
    rchk(`DDP_OFF_STAT, 32'h91);
    chk({31'h0, pins.busy}, 32'h1);
    waitidle();
    rchk(`DDP_OFF_STAT, 32'ha5);
    chk({31'h0, pins.motor}, 32'h1);
    clr();
    cmd(`DDP_C_SPIN, 8'h80);
    rchk(`DDP_OFF_STAT, 32'ha5);
    clr();
    fault_req <= 1'b1;
    cmd(`DDP_C_SPIN, 8'h00);
    rchk(`DDP_OFF_STAT, 32'hb1);
    waitidle();
    rchk(`DDP_OFF_STAT, 32'he5);
    clr();
    fault_req <= 1'b0;
    cmd(`DDP_C_SPIN, 8'h00);
    waitidle();
    rchk(`DDP_OFF_STAT, 32'h85);
    chk({31'h0, pins.motor}, 32'h0);
    clr();
    cmd(`DDP_C_SPT_HI, spt[0]);
    cmd(`DDP_C_SPT_MD, spt[1]);
    cmd(`DDP_C_SPT_LO, spt[2]);
    rchk(`DDP_OFF_SPT, 32'h123456);
    xfer(1'b1, `DDP_OFF_CTRL, 32'h2);
    waitidle();
    rchk(`DDP_OFF_STAT, 32'h85);
    for (int i = 0; i < 3; i++) begin
      cmd(`DDP_C_ATTR_NUM, `DDP_ATTR_SPT_HI + 8'(i));
      rchk(`DDP_OFF_ATTR, {16'h0, `DDP_ATTR_SPT_HI + 8'(i), spt[i]});
    end
    cmd(`DDP_C_TEST, 8'h5a);
    rchk(`DDP_OFF_TEST, 32'h5a);
    conclude();
  end
endmodule : test_disk_drive_param_out_commands
`default_nettype wire
